//--- msr_defs.vh
// Overview of operation
// - A 32-bit position target is kept, upper half at 0x4A and lower half at 0x4B, both zero at reset.
// - The position target counts whole revolutions plus the fraction of a turn, 65536 units per turn.
// - The applied position moves toward the target by a slope per 100 us, 0x0064 at reset.
// - In position mode the acceleration is a 5-bit value times 5760 rpm/s, 1 at reset.
// - Step resolution 4, 5, 6 and 7 select 4096, 2048, 1024 and 512 pulses per turn, zero at reset.
// - The 16-bit position-loop proportional gain sits at 0x1A and resets to 0x00FA.
// - The 16-bit position-loop gain ratio scales that gain and resets to 0x8008.
// - In position mode speed is capped in units per 50 us, 65536 per turn, 0x02FF at reset.
// - A 32-bit speed target is kept, its upper half at 0x4D resetting to 0x000A.
// - The lower half of the speed target sits at 0x4E and resets to zero.
// - The speed target is rpm / 60 * 2^32 / 10000, two's complement for reverse rotation.
// - The applied speed moves toward the speed target by a slope per 100 us per 100 us, 0x1300 at reset.
`ifndef MSR_DEFS_VH
`define MSR_DEFS_VH

`define MSR_OFS_POS_GAIN 8'h1a
`define MSR_OFS_POS_GAIN_RATIO 8'h1b
`define MSR_OFS_SPEED_CAP 8'h1c
`define MSR_OFS_ACCEL 8'h1d
`define MSR_OFS_POS_TGT_HI 8'h4a
`define MSR_OFS_POS_TGT_LO 8'h4b
`define MSR_OFS_POS_SLOPE 8'h4c
`define MSR_OFS_SPD_TGT_HI 8'h4d
`define MSR_OFS_SPD_TGT_LO 8'h4e
`define MSR_OFS_SPD_SLOPE 8'h4f
`define MSR_OFS_STEP_RES 8'h50

`define MSR_RST_POS_GAIN 16'h00fa
`define MSR_RST_POS_GAIN_RATIO 16'h8008
`define MSR_RST_SPEED_CAP 16'h02ff
`define MSR_RST_ACCEL 5'h01
`define MSR_RST_POS_TGT_HI 16'h0000
`define MSR_RST_POS_TGT_LO 16'h0000
`define MSR_RST_POS_SLOPE 16'h0064
`define MSR_RST_SPD_TGT_HI 16'h000a
`define MSR_RST_SPD_TGT_LO 16'h0000
`define MSR_RST_SPD_SLOPE 16'h1300
`define MSR_RST_STEP_RES 16'h0000
`define MSR_RST_ACCEL_RPM_S 18'h0_1680

`define MSR_ACCEL_W 5
`define MSR_ACCEL_UNIT_RPM_S 13'h1680

`define MSR_STEP_RES_4096 16'h0004
`define MSR_STEP_RES_2048 16'h0005
`define MSR_STEP_RES_1024 16'h0006
`define MSR_STEP_RES_512 16'h0007
`define MSR_PPT_4096 13'h1000
`define MSR_PPT_2048 13'h0800
`define MSR_PPT_1024 13'h0400
`define MSR_PPT_512 13'h0200

`define MSR_CLK_PERIOD_NS 100
`define MSR_SLOPE_INTERVAL_NS 100000
`define MSR_SLOPE_INTERVAL_CYCLES (`MSR_SLOPE_INTERVAL_NS / `MSR_CLK_PERIOD_NS)
`define MSR_CAP_INTERVAL_NS 50000
`define MSR_CAP_PER_SLOPE_INTERVAL (`MSR_SLOPE_INTERVAL_NS / `MSR_CAP_INTERVAL_NS)

`endif

//--- msr_interval_timer.v
module msr_interval_timer #(
  parameter PERIOD = 1000
) (
  // Clock and reset
  input wire i_clk,
  input wire i_resetn,
  // Tick output
  output reg o_tick
);

  localparam CW = 16;
  localparam [31:0] PERIOD_U = PERIOD;
  localparam [CW-1:0] LAST = PERIOD_U[CW-1:0] - 1'b1;

  reg [CW-1:0] count;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= {CW{1'b0}};
      o_tick <= 1'b0;
    end else if (count == LAST) begin
      count <= {CW{1'b0}};
      o_tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      o_tick <= 1'b0;
    end
  end

endmodule

//--- msr_slew_ramp.v
module msr_slew_ramp #(
  parameter W = 32
) (
  // Clock and reset
  input wire i_clk,
  input wire i_resetn,
  // Control
  input wire i_enable,
  input wire i_tick,
  input wire [W-1:0] i_target,
  input wire [W-1:0] i_step,
  // Ramped value
  output reg [W-1:0] o_value,
  output wire o_at_target
);

  // One extra bit keeps the signed distance from wrapping near full scale
  wire [W:0] diff = {i_target[W-1], i_target} - {o_value[W-1], o_value};
  wire below = diff[W];
  wire [W:0] mag = below ? ({(W+1){1'b0}} - diff) : diff;

  assign o_at_target = (o_value == i_target);

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_value <= {W{1'b0}};
    end else if (i_enable && i_tick && !o_at_target) begin
      if (mag <= {1'b0, i_step}) begin
        o_value <= i_target;
      end else if (below) begin
        o_value <= o_value - i_step;
      end else begin
        o_value <= o_value + i_step;
      end
    end
  end

endmodule

//--- msr_setpoint_regs.v
`include "msr_defs.vh"

module msr_setpoint_regs #(
  parameter SLOPE_INTERVAL_CYCLES = `MSR_SLOPE_INTERVAL_CYCLES
) (
  // Clock and reset
  input wire i_clk,
  input wire i_resetn,
  // Register port
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_wdata,
  output reg [15:0] o_reg_rdata,
  output reg o_reg_rvalid,
  output reg o_reg_err,
  // Operating mode
  input wire i_position_mode,
  // Position loop
  output reg [31:0] o_position_target,
  output wire [31:0] o_position_setpoint,
  output wire o_position_settled,
  output reg [15:0] o_position_step,
  output reg [15:0] o_position_loop_gain,
  output reg [15:0] o_position_loop_gain_ratio,
  output reg [15:0] o_position_mode_speed_cap,
  // Acceleration in position mode
  output reg [4:0] o_acceleration_rate,
  output reg [17:0] o_accel_rpm_per_s,
  // Pulse input scaling
  output reg [12:0] o_pulses_per_turn,
  output reg [7:0] o_pulse_position_step,
  output reg o_pulse_step_valid,
  // Speed loop
  output reg [31:0] o_speed_target_word,
  output wire [31:0] o_speed_setpoint,
  output wire o_speed_settled
);

  // Address map lookup, shared by the write and read paths
  function is_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `MSR_OFS_POS_GAIN,
        `MSR_OFS_POS_GAIN_RATIO,
        `MSR_OFS_SPEED_CAP,
        `MSR_OFS_ACCEL,
        `MSR_OFS_POS_TGT_HI,
        `MSR_OFS_POS_TGT_LO,
        `MSR_OFS_POS_SLOPE,
        `MSR_OFS_SPD_TGT_HI,
        `MSR_OFS_SPD_TGT_LO,
        `MSR_OFS_SPD_SLOPE,
        `MSR_OFS_STEP_RES: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  reg [15:0] position_target_high;
  reg [15:0] position_target_low;
  reg [15:0] position_ramp_slope;
  reg [15:0] speed_target_high;
  reg [15:0] speed_target_low;
  reg [15:0] speed_ramp_slope;
  reg [15:0] pulse_step_resolution;

  wire wr_hit = i_reg_wr && is_mapped(i_reg_addr);
  wire slope_tick;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_position_loop_gain <= `MSR_RST_POS_GAIN;
      o_position_loop_gain_ratio <= `MSR_RST_POS_GAIN_RATIO;
      o_position_mode_speed_cap <= `MSR_RST_SPEED_CAP;
      o_acceleration_rate <= `MSR_RST_ACCEL;
    end else if (wr_hit) begin
      case (i_reg_addr)
        `MSR_OFS_POS_GAIN: begin
          o_position_loop_gain <= i_reg_wdata;
        end
        `MSR_OFS_POS_GAIN_RATIO: begin
          o_position_loop_gain_ratio <= i_reg_wdata;
        end
        `MSR_OFS_SPEED_CAP: begin
          o_position_mode_speed_cap <= i_reg_wdata;
        end
        `MSR_OFS_ACCEL: begin
          o_acceleration_rate <= i_reg_wdata[`MSR_ACCEL_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      position_target_high <= `MSR_RST_POS_TGT_HI;
      position_target_low <= `MSR_RST_POS_TGT_LO;
      position_ramp_slope <= `MSR_RST_POS_SLOPE;
      speed_target_high <= `MSR_RST_SPD_TGT_HI;
      speed_target_low <= `MSR_RST_SPD_TGT_LO;
      speed_ramp_slope <= `MSR_RST_SPD_SLOPE;
      pulse_step_resolution <= `MSR_RST_STEP_RES;
    end else if (wr_hit) begin
      case (i_reg_addr)
        `MSR_OFS_POS_TGT_HI: begin
          position_target_high <= i_reg_wdata;
        end
        `MSR_OFS_POS_TGT_LO: begin
          position_target_low <= i_reg_wdata;
        end
        `MSR_OFS_POS_SLOPE: begin
          position_ramp_slope <= i_reg_wdata;
        end
        `MSR_OFS_SPD_TGT_HI: begin
          speed_target_high <= i_reg_wdata;
        end
        `MSR_OFS_SPD_TGT_LO: begin
          speed_target_low <= i_reg_wdata;
        end
        `MSR_OFS_SPD_SLOPE: begin
          speed_ramp_slope <= i_reg_wdata;
        end
        `MSR_OFS_STEP_RES: begin
          pulse_step_resolution <= i_reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Low half written last commits the pair; a lone upper-half write waits
  // coherent target commit
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_position_target <= {`MSR_RST_POS_TGT_HI, `MSR_RST_POS_TGT_LO};
      o_speed_target_word <= {`MSR_RST_SPD_TGT_HI, `MSR_RST_SPD_TGT_LO};
    end else if (wr_hit) begin
      if (i_reg_addr == `MSR_OFS_POS_TGT_LO) begin
        o_position_target <= {position_target_high, i_reg_wdata};
      end
      if (i_reg_addr == `MSR_OFS_SPD_TGT_LO) begin
        o_speed_target_word <= {speed_target_high, i_reg_wdata};
      end
    end
  end

  // Readback and unmapped-address answer
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
      o_reg_err <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      o_reg_err <= (i_reg_rd || i_reg_wr) && !is_mapped(i_reg_addr);
      if (i_reg_rd) begin
        case (i_reg_addr)
          `MSR_OFS_POS_GAIN: o_reg_rdata <= o_position_loop_gain;
          `MSR_OFS_POS_GAIN_RATIO: o_reg_rdata <= o_position_loop_gain_ratio;
          `MSR_OFS_SPEED_CAP: o_reg_rdata <= o_position_mode_speed_cap;
          `MSR_OFS_ACCEL: o_reg_rdata <= {11'h000, o_acceleration_rate};
          `MSR_OFS_POS_TGT_HI: o_reg_rdata <= position_target_high;
          `MSR_OFS_POS_TGT_LO: o_reg_rdata <= position_target_low;
          `MSR_OFS_POS_SLOPE: o_reg_rdata <= position_ramp_slope;
          `MSR_OFS_SPD_TGT_HI: o_reg_rdata <= speed_target_high;
          `MSR_OFS_SPD_TGT_LO: o_reg_rdata <= speed_target_low;
          `MSR_OFS_SPD_SLOPE: o_reg_rdata <= speed_ramp_slope;
          `MSR_OFS_STEP_RES: o_reg_rdata <= pulse_step_resolution;
          default: o_reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Cap is per 50 us while the slope is per 100 us, so the cap doubles
  wire [31:0] cap_product;
  wire [16:0] cap_per_interval;
  assign cap_product = o_position_mode_speed_cap * `MSR_CAP_PER_SLOPE_INTERVAL;
  assign cap_per_interval = cap_product[16:0];

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_position_step <= `MSR_RST_POS_SLOPE;
    end else if ({1'b0, position_ramp_slope} > cap_per_interval) begin
      o_position_step <= (cap_per_interval[16]) ? 16'hffff : cap_per_interval[15:0];
    end else begin
      o_position_step <= position_ramp_slope;
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_accel_rpm_per_s <= `MSR_RST_ACCEL_RPM_S;
    end else begin
      o_accel_rpm_per_s <= {13'h0000, o_acceleration_rate} * {5'h00, `MSR_ACCEL_UNIT_RPM_S};
    end
  end

  // Unlisted codes leave the pulse path disabled rather than guessing a scale
  // pulses per turn
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pulses_per_turn <= 13'h0000;
      o_pulse_position_step <= 8'h00;
      o_pulse_step_valid <= 1'b0;
    end else begin
      case (pulse_step_resolution)
        `MSR_STEP_RES_4096: begin
          o_pulses_per_turn <= `MSR_PPT_4096;
          o_pulse_position_step <= 8'h10;
          o_pulse_step_valid <= 1'b1;
        end
        `MSR_STEP_RES_2048: begin
          o_pulses_per_turn <= `MSR_PPT_2048;
          o_pulse_position_step <= 8'h20;
          o_pulse_step_valid <= 1'b1;
        end
        `MSR_STEP_RES_1024: begin
          o_pulses_per_turn <= `MSR_PPT_1024;
          o_pulse_position_step <= 8'h40;
          o_pulse_step_valid <= 1'b1;
        end
        `MSR_STEP_RES_512: begin
          o_pulses_per_turn <= `MSR_PPT_512;
          o_pulse_position_step <= 8'h80;
          o_pulse_step_valid <= 1'b1;
        end
        default: begin
          o_pulses_per_turn <= 13'h0000;
          o_pulse_position_step <= 8'h00;
          o_pulse_step_valid <= 1'b0;
        end
      endcase
    end
  end

  msr_interval_timer #(
    .PERIOD(SLOPE_INTERVAL_CYCLES)
  ) u_slope_timer (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .o_tick(slope_tick)
  );

  msr_slew_ramp #(
    .W(32)
  ) u_position_ramp (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_enable(i_position_mode),
    .i_tick(slope_tick),
    .i_target(o_position_target),
    .i_step({16'h0000, o_position_step}),
    .o_value(o_position_setpoint),
    .o_at_target(o_position_settled)
  );

  // Slope is already in speed-word units per interval, so it is not scaled
  // speed ramp
  msr_slew_ramp #(
    .W(32)
  ) u_speed_ramp (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_enable(!i_position_mode),
    .i_tick(slope_tick),
    .i_target(o_speed_target_word),
    .i_step({16'h0000, speed_ramp_slope}),
    .o_value(o_speed_setpoint),
    .o_at_target(o_speed_settled)
  );

endmodule

//--- msr_setpoint_regs_properties.sv
module msr_setpoint_regs_chk #(
  parameter SLOPE_INTERVAL_CYCLES = 1000
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [15:0] i_reg_wdata,
  input wire o_reg_rvalid,
  input wire i_position_mode,
  input wire [31:0] o_position_target,
  input wire [31:0] o_position_setpoint,
  input wire [15:0] o_position_loop_gain,
  input wire [4:0] o_acceleration_rate,
  input wire [17:0] o_accel_rpm_per_s,
  input wire [12:0] o_pulses_per_turn,
  input wire [31:0] o_speed_target_word,
  input wire [31:0] o_speed_setpoint
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_read_answer;
    i_reg_rd |=> o_reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_pos_commit;
    i_reg_wr && i_reg_addr == 8'h4b |=> o_position_target[15:0] == $past(i_reg_wdata);
  endproperty
  a_pos_commit: assert property (p_pos_commit) else $error("position low not committed");
  // A high half alone must leave the committed word alone
  property p_pos_coherent;
    i_reg_wr && i_reg_addr == 8'h4a |=> $stable(o_position_target);
  endproperty
  a_pos_coherent: assert property (p_pos_coherent) else $error("position word torn");
  property p_spd_commit;
    i_reg_wr && i_reg_addr == 8'h4e |=> o_speed_target_word[15:0] == $past(i_reg_wdata);
  endproperty
  a_spd_commit: assert property (p_spd_commit) else $error("speed low not committed");
  property p_spd_coherent;
    i_reg_wr && i_reg_addr == 8'h4d |=> $stable(o_speed_target_word);
  endproperty
  a_spd_coherent: assert property (p_spd_coherent) else $error("speed word torn");
  property p_gain;
    i_reg_wr && i_reg_addr == 8'h1a |=> o_position_loop_gain == $past(i_reg_wdata);
  endproperty
  a_gain: assert property (p_gain) else $error("gain not stored");
  property p_accel;
    i_reg_wr && i_reg_addr == 8'h1d |=> ##1 o_accel_rpm_per_s == $past(i_reg_wdata[4:0], 2) * 18'h0_1680;
  endproperty
  a_accel: assert property (p_accel) else $error("acceleration scaling wrong");
  property p_steps;
    i_reg_wr && i_reg_addr == 8'h50 && i_reg_wdata == 16'h0004 |=> ##1 o_pulses_per_turn == 13'h1000;
  endproperty
  a_steps: assert property (p_steps) else $error("pulses per turn wrong");
  property p_pos_freeze;
    !i_position_mode |=> $stable(o_position_setpoint);
  endproperty
  a_pos_freeze: assert property (p_pos_freeze) else $error("position ramp ran in speed mode");
  property p_spd_freeze;
    i_position_mode |=> $stable(o_speed_setpoint);
  endproperty
  a_spd_freeze: assert property (p_spd_freeze) else $error("speed ramp ran in position mode");
endmodule

bind msr_setpoint_regs msr_setpoint_regs_chk #(
  .SLOPE_INTERVAL_CYCLES(SLOPE_INTERVAL_CYCLES)
) msr_setpoint_regs_chk_i (.*);

//--- test_msr_setpoint_regs.sv
module test_msr_setpoint_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0;
  logic i_resetn = 0;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 0;
  logic i_reg_rd = 0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic i_position_mode = 0;
  wire [15:0] o_reg_rdata, o_position_step, o_position_loop_gain, o_position_loop_gain_ratio;
  wire [15:0] o_position_mode_speed_cap;
  wire o_reg_rvalid, o_reg_err, o_position_settled, o_pulse_step_valid, o_speed_settled;
  wire [31:0] o_position_target, o_position_setpoint, o_speed_target_word, o_speed_setpoint;
  wire [4:0] o_acceleration_rate;
  wire [17:0] o_accel_rpm_per_s;
  wire [12:0] o_pulses_per_turn;
  wire [7:0] o_pulse_position_step;
  int num_errors = 0;
  int compares = 0;
  logic [7:0] ofs [11] = '{8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e,
    8'h4f, 8'h50};
  logic [15:0] rst [11] = '{16'h00fa, 16'h8008, 16'h02ff, 16'h0001, 16'h0000, 16'h0000,
    16'h0064, 16'h000a, 16'h0000, 16'h1300, 16'h0000};
  logic [15:0] w;

  // Short ramp interval keeps the run brief
  msr_setpoint_regs #(.SLOPE_INTERVAL_CYCLES(10)) msr_setpoint_regs_i (.*);

  always #50 i_clk = ~i_clk;

  task conclude;
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input [31:0] g, input [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task wr(input [7:0] a, input [15:0] d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(negedge i_clk);
    i_reg_wr = 0;
  endtask

  task rd(input [7:0] a, input [15:0] e, input er);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd = 1;
    @(negedge i_clk);
    i_reg_rd = 0;
    chk({o_reg_rvalid, o_reg_err, o_reg_rdata}, {1'b1, er, e});
  endtask

  // Waits for speed settled (0), first position move (1), position settled (2)
  // or first speed move away from 0xfff50000 (3)
  task wait_for(input int k);
    int n;
    for (n = 0; n < 2000; n++) begin
      if (k == 3 && o_speed_setpoint !== 32'hfff5_0000)
        break;
      if (k == 0 && o_speed_settled === 1'b1)
        break;
      if (k == 1 && o_position_setpoint !== 32'h0000_0000)
        break;
      if (k == 2 && o_position_settled === 1'b1)
        break;
      @(negedge i_clk);
    end
    if (n == 2000) begin
      num_errors++;
      conclude;
    end
  endtask

  initial begin
    repeat (12) @(negedge i_clk);
    i_resetn = 1;
    chk(o_speed_target_word, 32'h000a_0000);
    chk(o_accel_rpm_per_s, 32'h0000_1680);
    chk(o_position_step, 32'h0000_0064);
    chk(o_pulse_step_valid, 32'h0000_0000);
    for (int i = 0; i < 11; i++) begin
      rd(ofs[i], rst[i], 1'b0);
    end
    for (int i = 0; i < 11; i++) begin
      w = 16'ha5c0 + i[15:0];
      wr(ofs[i], w);
      rd(ofs[i], (i == 3) ? (w & 16'h001f) : w, 1'b0);
    end
    chk(o_position_loop_gain, 32'h0000_a5c0);
    chk(o_position_loop_gain_ratio, 32'h0000_a5c1);
    chk(o_position_mode_speed_cap, 32'h0000_a5c2);
    chk(o_acceleration_rate, 32'h0000_0003);
    rd(8'h51, 16'h0000, 1'b1);
    wr(8'h4a, 16'h1234);
    chk(o_position_target, 32'ha5c4_a5c5);
    wr(8'h4b, 16'h5678);
    chk(o_position_target, 32'h1234_5678);
    wr(8'h4f, 16'h1300);
    wr(8'h4d, 16'hfff5);
    wr(8'h4e, 16'h0000);
    chk(o_speed_target_word, 32'hfff5_0000);
    wait_for(0);
    chk(o_speed_setpoint, 32'hfff5_0000);
    wr(8'h4f, 16'h0100);
    wr(8'h4e, 16'h0300);
    wait_for(3);
    chk(o_speed_setpoint, 32'hfff5_0100);
    wait_for(0);
    chk(o_speed_setpoint, 32'hfff5_0300);
    wr(8'h1c, 16'h02ff);
    wr(8'h4c, 16'h0064);
    wr(8'h4a, 16'h0000);
    wr(8'h4b, 16'h0300);
    chk(o_position_setpoint, 32'h0000_0000);
    i_position_mode = 1;
    wait_for(1);
    chk(o_position_setpoint, 32'h0000_0064);
    wait_for(2);
    chk(o_position_setpoint, 32'h0000_0300);
    wr(8'h1c, 16'h0010);
    @(negedge i_clk);
    chk(o_position_step, 32'h0000_0020);
    for (int c = 4; c < 8; c++) begin
      wr(8'h50, c[15:0]);
      @(negedge i_clk);
      chk(o_pulses_per_turn, 32'h0000_1000 >> (c - 4));
      chk(o_pulse_position_step, 32'h0000_0010 << (c - 4));
      chk(o_pulse_step_valid, 32'h0000_0001);
    end
    wr(8'h1d, 16'h001f);
    @(negedge i_clk);
    chk(o_accel_rpm_per_s, 32'h0002_b980);
    // Mid-run reset brings targets and ramps back to their reset values
    i_resetn = 0;
    @(negedge i_clk);
    i_resetn = 1;
    chk(o_position_target, 32'h0000_0000);
    chk(o_speed_target_word, 32'h000a_0000);
    chk(o_position_settled, 32'h0000_0001);
    chk(o_speed_settled, 32'h0000_0000);
    rd(8'h1a, 16'h00fa, 1'b0);
    conclude;
  end
endmodule
